//--- hdl/csscfg_defs.vh
// constants of the clock synthesizer configuration bank
`ifndef CSSCFG_DEFS_VH
`define CSSCFG_DEFS_VH

// bus addresses, read/write bit included
`define CSS_ADDR_WR 8'hd2
`define CSS_ADDR_RD 8'hd3

// byte offsets
`define CSS_OFS_CTRL 8'h00
`define CSS_OFS_OE_LO 8'h01
`define CSS_OFS_RSV2 8'h02
`define CSS_OFS_OE_HI 8'h03
`define CSS_OFS_RSV4 8'h04
`define CSS_OFS_SWING 8'h05
`define CSS_OFS_RSV6 8'h06
`define CSS_OFS_ID 8'h07
`define CSS_OFS_RSV8 8'h08
`define CSS_NUM_BYTES 8'h09

// field positions
`define CSS_BIT_SPREAD 5
`define CSS_BIT_GATE0 6
`define CSS_BIT_GATE1 3
`define CSS_BIT_GATE5 7
`define CSS_BIT_GATE4 6
`define CSS_POS_UPPER 6
`define CSS_POS_MID 4
`define CSS_POS_OUT0 0

// reset values
`define CSS_RST_SPREAD 1'b1
`define CSS_RST_GATE 1'b1
`define CSS_RST_UPPER 2'h1
`define CSS_RST_MID 2'h1
`define CSS_RST_OUT0 2'h1
`define CSS_RST_RSV 8'h00
`define CSS_RST_RSV8 8'h08

// identity codes, values arbitrary
`define CSS_REVISION 4'h3
`define CSS_MAKER 4'h5

// serial state codes
`define CSS_ST_IDLE 3'h0
`define CSS_ST_ADDR 3'h1
`define CSS_ST_INDEX 3'h2
`define CSS_ST_COUNT 3'h3
`define CSS_ST_WDATA 3'h4
`define CSS_ST_TX 3'h5

`endif

//--- hdl/csscfg_pair.v
// one gated differential clock pair
`timescale 1ns/100ps
`default_nettype none
module csscfg_pair (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // source phase and gate
  input wire src,
  input wire gate,
  // pair legs
  output reg leg_t,
  output reg leg_c
);
  always @(posedge clk) begin
    if (!rst_n) begin
      leg_t <= 1'b0;
      leg_c <= 1'b0;
    end else if (ce) begin
      leg_t <= gate & src;
      leg_c <= gate & ~src;
    end
  end
endmodule // csscfg_pair
`default_nettype wire

//--- hdl/csscfg_bank.v
// SMBus target and configuration bank of the clock synthesizer
`timescale 1ns/100ps
`default_nettype none
`include "csscfg_defs.vh"
module csscfg_bank (
  // clock, reset, enable
  input wire clk,
  input wire rst_n,
  input wire ce,
  // smbus pins
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n,
  // synthesizer phase to gate
  input wire src_phase,
  // configuration to the analog side
  output reg spread_on,
  output reg [1:0] upper_group_swing,
  output reg [1:0] mid_group_swing,
  output reg [1:0] out0_swing,
  // gated pairs
  output wire clock_pair_0_t,
  output wire clock_pair_0_c,
  output wire clock_pair_1_t,
  output wire clock_pair_1_c,
  output wire clock_pair_4_t,
  output wire clock_pair_4_c,
  output wire clock_pair_5_t,
  output wire clock_pair_5_c
);
  reg out0_gate;
  reg out1_gate;
  reg out4_gate;
  reg out5_gate;
  reg scl_r;
  reg sda_r;
  reg [2:0] state;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [7:0] index;
  reg [7:0] rd_byte;
  wire scl_rise;
  wire scl_fall;
  wire start_seen;
  wire stop_seen;
  wire [7:0] num_bytes;

  // count byte sent ahead of a read
  assign num_bytes = `CSS_NUM_BYTES;
  assign scl_rise = scl_in & ~scl_r;
  assign scl_fall = ~scl_in & scl_r;
  assign start_seen = scl_in & scl_r & sda_r & ~sda_in;
  assign stop_seen = scl_in & scl_r & ~sda_r & sda_in;

  // read view of the bank
  always @* begin
    rd_byte = 8'h00;
    case (index)
      `CSS_OFS_CTRL: rd_byte[`CSS_BIT_SPREAD] = spread_on;
      `CSS_OFS_OE_LO: begin
        rd_byte[`CSS_BIT_GATE0] = out0_gate;
        rd_byte[`CSS_BIT_GATE1] = out1_gate;
      end
      `CSS_OFS_OE_HI: begin
        rd_byte[`CSS_BIT_GATE5] = out5_gate;
        rd_byte[`CSS_BIT_GATE4] = out4_gate;
      end
      `CSS_OFS_SWING: begin
        rd_byte[`CSS_POS_UPPER+1:`CSS_POS_UPPER] = upper_group_swing;
        rd_byte[`CSS_POS_MID+1:`CSS_POS_MID] = mid_group_swing;
        rd_byte[`CSS_POS_OUT0+1:`CSS_POS_OUT0] = out0_swing;
      end
      `CSS_OFS_ID: rd_byte = {`CSS_REVISION, `CSS_MAKER};
      `CSS_OFS_RSV2: rd_byte = `CSS_RST_RSV;
      `CSS_OFS_RSV4: rd_byte = `CSS_RST_RSV;
      `CSS_OFS_RSV6: rd_byte = `CSS_RST_RSV;
      `CSS_OFS_RSV8: rd_byte = `CSS_RST_RSV8;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      state <= `CSS_ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      index <= 8'h00;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      spread_on <= `CSS_RST_SPREAD;
      out0_gate <= `CSS_RST_GATE;
      out1_gate <= `CSS_RST_GATE;
      out4_gate <= `CSS_RST_GATE;
      out5_gate <= `CSS_RST_GATE;
      upper_group_swing <= `CSS_RST_UPPER;
      mid_group_swing <= `CSS_RST_MID;
      out0_swing <= `CSS_RST_OUT0;
    end else if (ce) begin
      scl_r <= scl_in;
      sda_r <= sda_in;
      sda_out <= 1'b0;
      if (start_seen) begin
        // repeated start lands here too, keeping the index for a read
        state <= `CSS_ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_seen) begin
        state <= `CSS_ST_IDLE;
        bitcnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (state != `CSS_ST_IDLE) begin
        if (scl_rise) begin
          if (state == `CSS_ST_TX) begin
            if (bitcnt == 4'h9) begin
              // host nack ends the read at the next falling edge
              if (sda_in)
                bitcnt <= 4'ha;
            end else begin
              bitcnt <= bitcnt + 4'h1;
            end
          end else if (bitcnt < 4'h8) begin
            shreg <= {shreg[6:0], sda_in};
            bitcnt <= bitcnt + 4'h1;
          end
        end else if (scl_fall) begin
          if (state == `CSS_ST_TX) begin
            if (bitcnt < 4'h8) begin
              sda_oe_n <= shreg[7];
              shreg <= {shreg[6:0], 1'b0};
            end else if (bitcnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              bitcnt <= 4'h9;
            end else if (bitcnt == 4'h9) begin
              shreg <= {rd_byte[6:0], 1'b0};
              sda_oe_n <= rd_byte[7];
              index <= index + 8'h01;
              bitcnt <= 4'h0;
            end else begin
              state <= `CSS_ST_IDLE;
              sda_oe_n <= 1'b1;
            end
          end else if (bitcnt == 4'h8) begin
            sda_oe_n <= 1'b0;
            bitcnt <= 4'h9;
            case (state)
              `CSS_ST_ADDR: begin
                if (shreg == `CSS_ADDR_WR) begin
                  state <= `CSS_ST_INDEX;
                end else if (shreg == `CSS_ADDR_RD) begin
                  // stays in address state until its ack ends, then sends the count
                  state <= `CSS_ST_ADDR;
                end else begin
                  // not ours: stay off the bus until the next start
                  state <= `CSS_ST_IDLE;
                  sda_oe_n <= 1'b1;
                end
              end
              `CSS_ST_INDEX: begin
                index <= shreg;
                state <= `CSS_ST_COUNT;
              end
              // the count is acked but not enforced; stop ends the block
              `CSS_ST_COUNT: state <= `CSS_ST_WDATA;
              `CSS_ST_WDATA: begin
                index <= index + 8'h01;
                case (index)
                  `CSS_OFS_CTRL: spread_on <= shreg[`CSS_BIT_SPREAD];
                  `CSS_OFS_OE_LO: begin
                    out0_gate <= shreg[`CSS_BIT_GATE0];
                    out1_gate <= shreg[`CSS_BIT_GATE1];
                  end
                  `CSS_OFS_OE_HI: begin
                    out5_gate <= shreg[`CSS_BIT_GATE5];
                    out4_gate <= shreg[`CSS_BIT_GATE4];
                  end
                  `CSS_OFS_SWING: begin
                    upper_group_swing <= shreg[`CSS_POS_UPPER+1:`CSS_POS_UPPER];
                    mid_group_swing <= shreg[`CSS_POS_MID+1:`CSS_POS_MID];
                    out0_swing <= shreg[`CSS_POS_OUT0+1:`CSS_POS_OUT0];
                  end
                  // identity and reserved bytes ignore writes
                  default: index <= index + 8'h01;
                endcase
              end
              default: state <= `CSS_ST_IDLE;
            endcase
          end else if (bitcnt == 4'h9) begin
            bitcnt <= 4'h0;
            sda_oe_n <= 1'b1;
            if (state == `CSS_ST_ADDR && shreg == `CSS_ADDR_RD) begin
              // first byte of a read is the count of bank bytes
              state <= `CSS_ST_TX;
              shreg <= {num_bytes[6:0], 1'b0};
              sda_oe_n <= num_bytes[7];
            end
          end
        end
      end
    end
  end

  // one gated pair per enable bit
  csscfg_pair u_pair0 (
    .clk(clk), .rst_n(rst_n), .ce(ce), .src(src_phase), .gate(out0_gate),
    .leg_t(clock_pair_0_t), .leg_c(clock_pair_0_c)
  );
  csscfg_pair u_pair1 (
    .clk(clk), .rst_n(rst_n), .ce(ce), .src(src_phase), .gate(out1_gate),
    .leg_t(clock_pair_1_t), .leg_c(clock_pair_1_c)
  );
  csscfg_pair u_pair4 (
    .clk(clk), .rst_n(rst_n), .ce(ce), .src(src_phase), .gate(out4_gate),
    .leg_t(clock_pair_4_t), .leg_c(clock_pair_4_c)
  );
  csscfg_pair u_pair5 (
    .clk(clk), .rst_n(rst_n), .ce(ce), .src(src_phase), .gate(out5_gate),
    .leg_t(clock_pair_5_t), .leg_c(clock_pair_5_c)
  );
endmodule // csscfg_bank
`default_nettype wire

//--- tb/csscfg_host.sv
// smbus host model facing the configuration bank
`timescale 1ns/100ps
`default_nettype none
module csscfg_host (
  // clock
  input wire logic clk,
  // bus
  input wire logic sda,
  output var logic scl,
  output var logic sda_dn
);
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // four clocks a phase, above the three the target needs
  task automatic hold;
    repeat (4) @(negedge clk);
  endtask
  task automatic bit1(input logic b, output logic r);
    sda_dn = ~b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
    scl = 1'b0;
    hold();
  endtask
  // also serves as repeated start
  task automatic start;
    sda_dn = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_dn = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop;
    sda_dn = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_dn = 1'b0;
    hold();
  endtask
  // msb first, ninth bit last; ab high leaves the wire to the target
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                      output logic a);
    for (int i = 7; i >= 0; i--)
      bit1(d[i], q[i]);
    bit1(ab, a);
  endtask
endmodule // csscfg_host
`default_nettype wire

//--- tb/csscfg_chk.sv
// assertions on the configuration bank ports
`timescale 1ns/100ps
`default_nettype none
module csscfg_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // settings and pairs
  input wire logic src_phase,
  input wire logic spread_on,
  input wire logic [1:0] upper_group_swing,
  input wire logic [1:0] mid_group_swing,
  input wire logic [1:0] out0_swing,
  input wire logic clock_pair_0_t,
  input wire logic clock_pair_0_c,
  input wire logic clock_pair_5_t,
  input wire logic clock_pair_5_c
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sda_out_zero_a: assert property (sda_out == 1'b0)
    else $error("sda output not low");
  reset_values_a: assert property (disable iff (1'b0) !rst_n && ce |=> spread_on &&
    upper_group_swing == 2'h1 && mid_group_swing == 2'h1 && out0_swing == 2'h1)
    else $error("reset values wrong");
  reset_release_a: assert property (disable iff (1'b0) !rst_n && ce |=> sda_oe_n &&
    !clock_pair_0_t && !clock_pair_5_c) else $error("outputs active in reset");
  pair_exclusive_a: assert property (!(clock_pair_0_t && clock_pair_0_c) &&
    !(clock_pair_5_t && clock_pair_5_c)) else $error("both legs high");
  pair_follow_a: assert property (clock_pair_0_t |-> $past(src_phase))
    else $error("pair runs without phase");
  drive_stands_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda drive moved with clock high");
  start_no_drive_a: assert property ($fell(sda_in) && scl_in |-> sda_oe_n)
    else $error("target pulled sda at start");
  cfg_on_low_a: assert property (!$stable({spread_on, upper_group_swing, out0_swing})
    |-> !scl_in) else $error("setting moved with clock high");
endmodule // csscfg_chk
`default_nettype wire

//--- tb/clock_synth_smbus_config_bank_test.sv
// self-checking bench of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module clock_synth_smbus_config_bank_test;
  logic clk, rst_n, src_phase, scl, sda_dn, sda_out, sda_oe_n, spread_on, a;
  logic [1:0] upper_group_swing, mid_group_swing, out0_swing;
  logic clock_pair_0_t, clock_pair_0_c, clock_pair_1_t, clock_pair_1_c;
  logic clock_pair_4_t, clock_pair_4_c, clock_pair_5_t, clock_pair_5_c;
  logic [7:0] m [9];
  logic [7:0] q;
  int n_mismatch, n_tests, cyc, i0;
  wire sda;
  // pull-up: a released wire reads high
  assign sda = ~(sda_dn | ~sda_oe_n);
  csscfg_bank u_dut (.clk, .rst_n, .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe_n, .src_phase, .spread_on, .upper_group_swing, .mid_group_swing, .out0_swing,
    .clock_pair_0_t, .clock_pair_0_c, .clock_pair_1_t, .clock_pair_1_c, .clock_pair_4_t,
    .clock_pair_4_c, .clock_pair_5_t, .clock_pair_5_c);
  csscfg_host u_host (.clk, .sda, .scl, .sda_dn);
  function automatic logic [7:0] fold(input int i, input logic [7:0] d);
    case (i)
      0: return d & 8'h20;
      1: return d & 8'h48;
      3: return d & 8'hc0;
      5: return d & 8'hf3;
      7: return 8'h35;
      8: return 8'h08;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic reset_all;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++)
      m[i] = fold(i, 8'hff);
    m[5] = 8'h51;
    @(negedge clk);
  endtask
  task automatic head(input int idx);
    u_host.start();
    u_host.xfer(8'hd2, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_host.xfer(8'(idx), 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
  endtask
  task automatic wr(input int idx, input int n, input logic [7:0] pat, input bit rnd);
    logic [7:0] d;
    head(idx);
    u_host.xfer(8'(n), 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      d = rnd ? 8'($urandom) : pat;
      u_host.xfer(d, 1'b1, q, a);
      chk({7'h0, a}, 8'h00);
      if (idx + i < 9)
        m[idx + i] = fold(idx + i, d);
    end
    u_host.stop();
  endtask
  task automatic rd(input int idx, input int n);
    head(idx);
    u_host.start();
    u_host.xfer(8'hd3, 1'b1, q, a);
    chk({7'h0, a}, 8'h00);
    u_host.xfer(8'hff, 1'b0, q, a);
    chk(q, 8'h09);
    for (int i = 0; i < n; i++) begin
      u_host.xfer(8'hff, 1'(i == n - 1), q, a);
      chk(q, (idx + i < 9) ? m[idx + i] : 8'h00);
    end
    u_host.stop();
  endtask
  // legs now carry the phase launched at the previous falling edge
  task automatic pchk(input string s);
    @(negedge clk);
    chk({spread_on, upper_group_swing, mid_group_swing, out0_swing}, 8'({m[0][5], m[5][7:4],
      m[5][1:0]}));
    chk({clock_pair_0_t, clock_pair_0_c, clock_pair_1_t, clock_pair_1_c}, {m[1][6] & src_phase,
      m[1][6] & ~src_phase, m[1][3] & src_phase, m[1][3] & ~src_phase});
    chk({clock_pair_4_t, clock_pair_4_c, clock_pair_5_t, clock_pair_5_c}, {m[3][6] & src_phase,
      m[3][6] & ~src_phase, m[3][7] & src_phase, m[3][7] & ~src_phase});
    $display("test %0s over", s);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk)
    src_phase <= 1'($urandom);
  // whole run needs about 22000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(87434));
    src_phase = 1'b0;
    reset_all();
    rd(0, 9);
    pchk("power-up values");
    for (int k = 0; k < 6; k++) begin
      i0 = $urandom_range(8);
      wr(i0, $urandom_range(9 - i0, 1), 8'h00, 1'b1);
      rd(0, 9);
      pchk("random block write");
    end
    wr(0, 9, 8'h00, 1'b0);
    rd(0, 11);
    pchk("all cleared");
    wr(0, 9, 8'hff, 1'b0);
    rd(5, 6);
    pchk("all set");
    u_host.start();
    u_host.xfer(8'hd4, 1'b1, q, a);
    chk({7'h0, a}, 8'h01);
    u_host.stop();
    wr(1, 1, 8'h00, 1'b0);
    reset_all();
    rd(0, 9);
    pchk("stray address and reset");
    wrap_up();
  end
endmodule // clock_synth_smbus_config_bank_test
bind csscfg_bank csscfg_chk u_chk (.clk, .rst_n, .ce, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .src_phase, .spread_on, .upper_group_swing, .mid_group_swing, .out0_swing, .clock_pair_0_t,
  .clock_pair_0_c, .clock_pair_5_t, .clock_pair_5_c);
`default_nettype wire
